// ===== rtl/waveform_segment_sequencer.sv
// Sequencer that steps a waveform generator through a segment list
`timescale 1ns/1ps
//
// Overview of operation
// - Ordered list of segments, each with waveform, loop mode and advance condition.
// - Continuous loop replays the waveform until an advance trigger on a triggered segment, or plays it once when advance is automatic.
// - Each segment advances automatically or waits for an advance trigger.
// - Edge condition latches an advance trigger until the advance happens.
// - Level condition uses only the current trigger state, no latch.
// - Synchronous timing defers a triggered change to the end of the cycle.
// - Immediate timing switches segment at once, abandoning the cycle.
// - A start trigger begins the sequence at its first segment.
// - Internal periodic trigger can feed start and advance triggers.
// - After the last segment of the final repeat the output holds the baseline value.
// - After the repeat count, wait for a start trigger and restart.
// - Marker low while running, high while resting at baseline.
// - Marker gives a narrow positive pulse at each segment start.
module waveform_segment_sequencer
#(
	parameter int TRIG_PERIOD = wss_pkg::TRIG_PERIOD_CYC
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Segment list
	input wire wss_pkg::segment_t segList [wss_pkg::NUM_SEGS],
	input wire logic [wss_pkg::SEG_IDX_W-1:0] lastSeg,
	input wire logic [wss_pkg::REP_W-1:0] seqRepeat,
	// Trigger setup and pins
	input wire wss_pkg::advance_trigger_setup_t advance_trigger_setup,
	input wire logic [wss_pkg::TRIG_CNT_W-1:0] internPeriod,
	input wire logic startTrigPin,
	input wire logic advTrigPin,
	// Output stage
	output wss_pkg::sample_req_t sampleReq,
	output logic segment_marker_output,
	output logic running,
	output logic [wss_pkg::SEG_IDX_W-1:0] curSeg
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		wss_pkg::seq_state_t state;
		logic [wss_pkg::SEG_IDX_W-1:0] seg;
		logic [wss_pkg::ADDR_W-1:0] addr;
		logic [wss_pkg::LOOP_W-1:0] loops;
		logic [wss_pkg::REP_W-1:0] reps;
		logic advLatch;
		logic [wss_pkg::TRIG_CNT_W-1:0] tick;
		logic [2:0] pulse;
		wss_pkg::sample_req_t req;
		logic marker;
		logic run;
	} seq_regs_t;

	seq_regs_t cur_ff;
	seq_regs_t nxt_ff;

	logic startLvl;
	logic startRise;
	logic advLvl;
	logic advRise;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	trig_sync startSync
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.pinIn(startTrigPin),
		.level(startLvl),
		.rise(startRise)
	);

	trig_sync advSync
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.pinIn(advTrigPin),
		.level(advLvl),
		.rise(advRise)
	);

	// Period of the internal trigger; zero falls back to the default
	function automatic logic [wss_pkg::TRIG_CNT_W-1:0] periodOf(input logic [wss_pkg::TRIG_CNT_W-1:0] p);
		periodOf = (p == '0) ? wss_pkg::TRIG_CNT_W'(TRIG_PERIOD) : p;
	endfunction

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Internal source or synchronised pin, as the setup selects
	function automatic logic pickSrc(input logic useIntern, input logic intern, input logic ext);
		pickSrc = useIntern ? intern : ext;
	endfunction

	// The last address is inclusive, so one cycle is waveLen plus one samples
	function automatic logic cycleDone(input logic [wss_pkg::ADDR_W-1:0] a, input logic [wss_pkg::ADDR_W-1:0] len);
		cycleDone = (a >= len);
	endfunction

	// A loop count of zero acts as one; the extra bit keeps a full count from wrapping
	function automatic logic countDone(input logic [wss_pkg::LOOP_W-1:0] done, input logic [wss_pkg::LOOP_W-1:0] want);
		countDone = (({1'b0, done} + 17'h1) >= {1'b0, want});
	endfunction

	// A repeat count of zero acts as one
	function automatic logic seqDone(input logic [wss_pkg::REP_W-1:0] done, input logic [wss_pkg::REP_W-1:0] want);
		seqDone = (({1'b0, done} + 9'h1) >= {1'b0, want});
	endfunction

	// Consuming wins, so one remembered edge gives exactly one advance
	function automatic logic edgeLatch(input logic latch, input logic edgeIn, input logic taken);
		edgeLatch = taken ? 1'b0 : (latch | edgeIn);
	endfunction

	// High at rest; while running only the segment start pulse lifts it
	function automatic logic markerOf(input logic run, input logic [2:0] pulse);
		markerOf = ~run | (pulse != 3'h0);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic internTick;
		logic startEv;
		logic advEdge;
		logic advNow;
		logic cycleEnd;
		logic leaveSeg;
		logic advTaken;
		wss_pkg::segment_t s;
		internTick = 1'b0;
		startEv = 1'b0;
		advEdge = 1'b0;
		advNow = 1'b0;
		cycleEnd = 1'b0;
		leaveSeg = 1'b0;
		advTaken = 1'b0;
		s = segList[cur_ff.seg];
		nxt_ff = cur_ff;

		// ----------------------------------------
		// Trigger sources
		// ----------------------------------------

		// Internal periodic trigger
		if (cur_ff.tick >= periodOf(internPeriod) - 1'b1)
		begin
			nxt_ff.tick = '0;
			internTick = 1'b1;
		end
		else
			nxt_ff.tick = cur_ff.tick + 1'b1;

		startEv = pickSrc(advance_trigger_setup.startFromIntern, internTick, startRise);
		advEdge = pickSrc(advance_trigger_setup.advFromIntern, internTick, advRise);

		// Edge condition remembers the trigger; level just looks at the selected source
		if (advance_trigger_setup.levelCond)
		begin
			nxt_ff.advLatch = 1'b0;
			// With the internal source the tick itself stands in for the level
			advNow = pickSrc(advance_trigger_setup.advFromIntern, internTick, advLvl);
		end
		else
		begin
			advNow = cur_ff.advLatch | advEdge;
		end

		// Pulse counter runs down by itself; each segment start reloads it
		if (cur_ff.pulse != '0)
			nxt_ff.pulse = cur_ff.pulse - 1'b1;

		// ----------------------------------------
		// Segment player
		// ----------------------------------------

		unique case (cur_ff.state)
			wss_pkg::ST_IDLE,
			wss_pkg::ST_BASE:
			begin
				// Start triggers are looked at only here, so they are ignored during play
				if (startEv)
				begin
					nxt_ff.state = wss_pkg::ST_PLAY;
					nxt_ff.seg = '0;
					nxt_ff.addr = '0;
					nxt_ff.loops = '0;
					nxt_ff.reps = '0;
					nxt_ff.advLatch = 1'b0;
					nxt_ff.pulse = wss_pkg::PULSE_LEN;
				end
			end
			wss_pkg::ST_PLAY:
			begin
				cycleEnd = cycleDone(cur_ff.addr, s.waveLen);
				if (s.trigAdvance)
				begin
					if (advNow && (advance_trigger_setup.immediateAdvance || cycleEnd))
					begin
						leaveSeg = 1'b1;
						advTaken = 1'b1;
					end
				end
				else if (s.loopMode == wss_pkg::LOOP_COUNT)
				begin
					if (cycleEnd && countDone(cur_ff.loops, s.loopCount))
						leaveSeg = 1'b1;
				end
				else if (cycleEnd)
				begin
					leaveSeg = 1'b1;
				end

				if (leaveSeg)
				begin
					nxt_ff.addr = '0;
					nxt_ff.loops = '0;
					nxt_ff.pulse = wss_pkg::PULSE_LEN;
					if (cur_ff.seg == lastSeg)
					begin
						if (seqDone(cur_ff.reps, seqRepeat))
						begin
							nxt_ff.state = wss_pkg::ST_BASE;
							nxt_ff.pulse = '0;
						end
						nxt_ff.reps = cur_ff.reps + 1'b1;
						nxt_ff.seg = '0;
					end
					else
						nxt_ff.seg = cur_ff.seg + 1'b1;
				end
				else if (cycleEnd)
				begin
					nxt_ff.addr = '0;
					nxt_ff.loops = cur_ff.loops + 1'b1;
				end
				else
					nxt_ff.addr = cur_ff.addr + 1'b1;

				if (!advance_trigger_setup.levelCond)
					nxt_ff.advLatch = edgeLatch(cur_ff.advLatch, advEdge, advTaken);
			end
			default:
			begin
				// A corrupted state code falls back to rest instead of hanging
				nxt_ff.state = wss_pkg::ST_IDLE;
				nxt_ff.seg = '0;
				nxt_ff.addr = '0;
			end
		endcase

		// ----------------------------------------
		// Output image
		// ----------------------------------------

		// Baseline follows the next state, so the sample and the run flag change together
		nxt_ff.req.useBaseline = (nxt_ff.state != wss_pkg::ST_PLAY);
		nxt_ff.req.waveId = segList[nxt_ff.seg].waveId;
		nxt_ff.req.addr = nxt_ff.addr;
		nxt_ff.run = (nxt_ff.state == wss_pkg::ST_PLAY);
		// Low while running, pulsed high at each segment start
		nxt_ff.marker = markerOf(nxt_ff.run, nxt_ff.pulse);
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			// Marker and baseline rest high so the output stage sees idle from the first edge
			cur_ff <= '0;
			cur_ff.state <= wss_pkg::ST_IDLE;
			cur_ff.req.useBaseline <= 1'b1;
			cur_ff.marker <= 1'b1;
		end
		else
			cur_ff <= nxt_ff;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sampleReq = cur_ff.req;
	assign segment_marker_output = cur_ff.marker;
	assign running = cur_ff.run;
	assign curSeg = cur_ff.seg;

endmodule

// ===== rtl/wss_pkg.sv
// Package of types and constants for the waveform segment sequencer
package wss_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int SEG_IDX_W = 3;
	localparam int NUM_SEGS = 8;
	localparam int WAVE_ID_W = 4;
	localparam int ADDR_W = 12;
	localparam int SAMPLE_W = 12;
	localparam int LOOP_W = 16;
	localparam int REP_W = 8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int TRIG_PERIOD_US = 2000;
	localparam int TRIG_PERIOD_CYC = (TRIG_PERIOD_US * 1000000) / CLK_PERIOD_PS;
	localparam int TRIG_CNT_W = 32;
	localparam int PULSE_CYC = 4;
	localparam logic [2:0] PULSE_LEN = 3'(PULSE_CYC);

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [SAMPLE_W-1:0] BASELINE_RST = 12'h800;
	localparam logic [REP_W-1:0] REP_RST = 8'h01;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [0:0]
	{
		LOOP_CONT = 1'b0,
		LOOP_COUNT = 1'b1
	} loop_mode_t;

	// One segment of the list
	typedef struct packed
	{
		logic [WAVE_ID_W-1:0] waveId;
		logic [ADDR_W-1:0] waveLen;
		loop_mode_t loopMode;
		logic [LOOP_W-1:0] loopCount;
		logic trigAdvance;
	} segment_t;

	// Advance trigger setup
	typedef struct packed
	{
		logic levelCond;
		logic immediateAdvance;
		logic advFromIntern;
		logic startFromIntern;
	} advance_trigger_setup_t;

	// Output sample request to the waveform memory
	typedef struct packed
	{
		logic [WAVE_ID_W-1:0] waveId;
		logic [ADDR_W-1:0] addr;
		logic useBaseline;
	} sample_req_t;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_PLAY = 3'b010,
		ST_BASE = 3'b100
	} seq_state_t;

endpackage

// ===== rtl/trig_sync.sv
// Pin synchroniser with rising edge detect for one trigger input
`timescale 1ns/1ps
module trig_sync
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Pin and results
	input wire logic pinIn,
	output logic level,
	output logic rise
);

	typedef struct packed
	{
		logic meta;
		logic sync;
		logic prev;
	} sync_state_t;

	sync_state_t cur_ff;
	sync_state_t nxt_ff;

	always_comb
	begin
		nxt_ff.meta = pinIn;
		nxt_ff.sync = cur_ff.meta;
		nxt_ff.prev = cur_ff.sync;
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			cur_ff <= '0;
		else
			cur_ff <= nxt_ff;
	end

	assign level = cur_ff.sync;
	assign rise = cur_ff.sync & ~cur_ff.prev;

endmodule

// ===== sim/trig_src.sv
// Partner model of one trigger source pin
`timescale 1ns/1ps
module trig_src
(
	// Request from the bench
	input wire logic fire,
	// Pin to the sequencer
	output logic pin
);
	// Skew keeps pin edges off the sampling edge, as a free-running source would be
	assign #1.5 pin = fire;
endmodule

// ===== sim/waveform_segment_sequencer_properties.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module waveform_segment_sequencer_properties
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Setup
	input wire wss_pkg::segment_t segList [wss_pkg::NUM_SEGS],
	input wire logic [wss_pkg::SEG_IDX_W-1:0] lastSeg,
	input wire wss_pkg::advance_trigger_setup_t advance_trigger_setup,
	// Outputs
	input wire wss_pkg::sample_req_t sampleReq,
	input wire logic segment_marker_output,
	input wire logic running,
	input wire logic [wss_pkg::SEG_IDX_W-1:0] curSeg
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	a_idle_base: assert property (!running |-> segment_marker_output && sampleReq.useBaseline)
		else $error("idle without baseline or high marker");
	a_start_first: assert property ($rose(running) |-> curSeg == 0 && sampleReq.addr == 0)
		else $error("sequence did not start at first segment");
	a_start_pulse: assert property ($rose(running) |-> segment_marker_output [*4] ##1 !segment_marker_output)
		else $error("start pulse wrong");
	a_seg_pulse: assert property (running && $changed(curSeg) |-> segment_marker_output)
		else $error("no pulse at segment start");
	a_addr_step: assert property (running && $past(running) && $stable(curSeg) && sampleReq.addr != 0
		|-> sampleReq.addr == 12'($past(sampleReq.addr) + 1))
		else $error("address did not step");
	a_sync_end: assert property (running && $past(running) && $changed(curSeg) && !advance_trigger_setup.immediateAdvance
		|-> $past(sampleReq.addr) == segList[$past(curSeg)].waveLen)
		else $error("segment left mid cycle");
	a_seg_order: assert property (running && $past(running) && $changed(curSeg)
		|-> curSeg == $past(curSeg) + 3'h1 || curSeg == 0)
		else $error("segment order broken");
	a_ended_last: assert property ($fell(running) |-> $past(curSeg) == lastSeg)
		else $error("stopped before last segment");
	a_play_wave: assert property (running |-> !sampleReq.useBaseline)
		else $error("baseline requested while running");
	a_wave_id: assert property (running |-> sampleReq.waveId == segList[curSeg].waveId)
		else $error("waveform id does not match segment");
endmodule

bind waveform_segment_sequencer waveform_segment_sequencer_properties chk (.core_clk, .resetn, .segList, .lastSeg,
	.advance_trigger_setup, .sampleReq, .segment_marker_output, .running, .curSeg);

// ===== sim/waveform_segment_sequencer_tb.sv
// Self-checking bench for the waveform segment sequencer
`timescale 1ns/1ps
module waveform_segment_sequencer_tb;
	logic core_clk = 0;
	logic resetn = 0;
	wss_pkg::segment_t segList [wss_pkg::NUM_SEGS];
	logic [2:0] lastSeg = 3'h2;
	logic [7:0] seqRepeat = 8'h01;
	wss_pkg::advance_trigger_setup_t setup = '0;
	logic [31:0] internPeriod = 32'h0;
	logic startFire = 0;
	logic advFire = 0;
	logic startTrigPin, advTrigPin, running, segment_marker_output, prevRun;
	wss_pkg::sample_req_t sampleReq;
	logic [2:0] curSeg, prevSeg;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	int len = 0;
	int lens[$];
	integer seed = 5209;

	always #2 core_clk = ~core_clk;

	waveform_segment_sequencer #(.TRIG_PERIOD(40)) dut (.core_clk, .resetn, .segList, .lastSeg, .seqRepeat,
		.advance_trigger_setup(setup), .internPeriod, .startTrigPin, .advTrigPin, .sampleReq,
		.segment_marker_output, .running, .curSeg);
	trig_src srcStart (.fire(startFire), .pin(startTrigPin));
	trig_src srcAdv (.fire(advFire), .pin(advTrigPin));

	// ----
	// Segment length monitor and hang guard
	// ----
	always @(negedge core_clk)
	begin
		cyc++;
		if (prevRun === 1'b1 && (running !== 1'b1 || curSeg !== prevSeg))
		begin
			lens.push_back(len);
			len = 0;
		end
		if (running === 1'b1)
			len++;
		prevRun = running;
		prevSeg = curSeg;
		if (cyc > 5000)
		begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----
	// One pass: seg0 triggered continuous, seg1 counted, seg2 automatic
	// ----
	task automatic go(input logic [3:0] s, input int advAt, input logic lvl);
		int l[3];
		int n;
		setup = s;
		lens = {};
		for (int i = 0; i < 3; i++)
			l[i] = 8 + ($random(seed) & 7);
		n = 1 + ($random(seed) & 3);
		segList[0] = {4'h1, 12'(l[0]), wss_pkg::LOOP_CONT, 16'h0, 1'b1};
		segList[1] = {4'h2, 12'(l[1]), wss_pkg::LOOP_COUNT, 16'(n), 1'b0};
		segList[2] = {4'h3, 12'(l[2]), wss_pkg::LOOP_CONT, 16'h0, 1'b0};
		startFire = !s[0];
		advFire = lvl;
		tick(4);
		startFire = 0;
		while (running !== 1'b1)
			tick(1);
		if (advAt > 0)
		begin
			tick(advAt);
			advFire = 1;
			tick(4);
			advFire = 0;
		end
		while (running !== 1'b0)
			tick(1);
		// Internal start off at once, so the next tick cannot relaunch the finished run
		setup.startFromIntern = 1'b0;
		advFire = 0;
		tick(1);
		check(lens.size(), 3 * seqRepeat);
		check(lens[1], n * (l[1] + 1));
		check(lens[2], l[2] + 1);
		if (s[2])
			check(lens[0] < advAt + 8, 1);
		else
			check(lens[0] % (l[0] + 1), 0);
		if (lvl)
			check(lens[0], l[0] + 1);
		check(sampleReq.useBaseline, 1);
		check(segment_marker_output, 1);
		$display("test %h done", s);
	endtask

	initial
	begin
		for (int i = 0; i < 8; i++)
			segList[i] = '0;
		tick(4);
		resetn = 1;
		tick(2);
		go(4'h0, 30, 0);
		go(4'h4, 30, 0);
		go(4'h8, 0, 1);
		seqRepeat = 8'h02;
		go(4'h3, 0, 0);
		setup = 4'h0;
		tick(60);
		check(running, 0);
		give_verdict();
	end
endmodule
